// file: pkg/ats_regs.vh
// Register map, field layout and trigger codes of the trigger select block
`ifndef ATS_REGS_VH
`define ATS_REGS_VH

// ============================================================
// Register offsets (byte addresses)
`define ATS_ADDR_W            8
`define ATS_OFF_TRIG_SEL      8'h14
`define ATS_OFF_UFLOW         8'h18
`define ATS_OFF_INITIATE      8'h28
`define ATS_OFF_SEQ_ENABLE    8'h00
`define ATS_OFF_INT_MASK      8'h30

// ============================================================
// Field layout
`define ATS_NSEQ              4
`define ATS_FIELD_W           4
`define ATS_TRIG_RESET        16'h0000
`define ATS_FLAGS_RESET       4'h0
`define ATS_ZERO32            32'h0000_0000

// ============================================================
// Trigger codes
`define ATS_TRIG_PROC         4'h0
`define ATS_TRIG_COMP0        4'h1
`define ATS_TRIG_EXT_PIN      4'h4
`define ATS_TRIG_TIMER        4'h5
`define ATS_TRIG_PGEN_A       4'h6
`define ATS_TRIG_PGEN_B       4'h7
`define ATS_TRIG_PGEN_C       4'h8
`define ATS_TRIG_ALWAYS       4'hf

`endif

// file: core/ats_trig_mux.v
// One sequencer's trigger selector: code table to start pulse
`timescale 1ns/100ps

module ats_trig_mux (
    // Clock and reset
    input  wire       clk,
    input  wire       srst,
    input  wire       clk_en,
    // Selection
    input  wire [3:0] field,
    input  wire       enabled,
    input  wire       initiate,
    // Trigger events
    input  wire       comp0_evt,
    input  wire       ext_pin_evt,
    input  wire       timer_evt,
    input  wire       pgen_a_evt,
    input  wire       pgen_b_evt,
    input  wire       pgen_c_evt,
    // Result
    output reg        start_q
);
`include "ats_regs.vh"

    // ============================================================
    // Decode
    function sel_event;
        input [3:0] code;
        input       ini;
        input       c0;
        input       ep;
        input       tm;
        input       pa;
        input       pb;
        input       pc;
        begin
            case (code)
                `ATS_TRIG_PROC:    sel_event = ini;
                `ATS_TRIG_COMP0:   sel_event = c0;
                `ATS_TRIG_EXT_PIN: sel_event = ep;
                `ATS_TRIG_TIMER:   sel_event = tm;
                `ATS_TRIG_PGEN_A:  sel_event = pa;
                `ATS_TRIG_PGEN_B:  sel_event = pb;
                `ATS_TRIG_PGEN_C:  sel_event = pc;
                `ATS_TRIG_ALWAYS:  sel_event = 1'b1;
                // Reserved codes never start sampling
                default:           sel_event = 1'b0;
            endcase
        end
    endfunction

    wire start_d = enabled & sel_event(field, initiate, comp0_evt, ext_pin_evt,
                                       timer_evt, pgen_a_evt, pgen_b_evt, pgen_c_evt);

    always @(posedge clk) begin
        if (srst) begin
            start_q <= 1'b0;
        end else if (clk_en) begin
            start_q <= start_d;
        end
    end

endmodule

// file: core/ats_top.v
// Trigger source select and FIFO underflow flags of the converter sequencers
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps

module ats_top #(
    parameter NSEQ = 4,
    parameter DW   = 32
) (
    // Clock, reset, enable
    input  wire            clk,
    input  wire            srst,
    input  wire            clk_en,
    // Register port
    input  wire [7:0]      reg_addr,
    input  wire [31:0]     reg_wdata,
    input  wire            reg_wr,
    input  wire            reg_rd,
    output reg  [31:0]     reg_rdata_q,
    // Trigger sources
    input  wire            comp0_evt,
    input  wire            external_trigger_pin,
    input  wire            timer_evt,
    input  wire            pulse_gen_a_trigger,
    input  wire            pulse_gen_b_trigger,
    input  wire            pulse_gen_c_trigger,
    // Sequencer starts
    output wire [NSEQ-1:0] seq_start_q,
    // FIFO read side
    input  wire [NSEQ-1:0] fifo_rd_req,
    input  wire [NSEQ-1:0] fifo_empty,
    input  wire [DW-1:0]   fifo_rd_data,
    output reg  [NSEQ-1:0] fifo_pop_q,
    output reg  [DW-1:0]   rd_data_q,
    output reg             rd_valid_q,
    // Interrupt
    output reg             irq_q
);
`include "ats_regs.vh"

    // ============================================================
    // Register state
    reg [15:0]     trigger_source_select_q;
    reg [NSEQ-1:0] fifo_underflow_flags_q;
    reg [NSEQ-1:0] sequencer_active_enable_q;
    reg [NSEQ-1:0] int_mask_q;
    reg [NSEQ-1:0] initiate_q;

    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    wire wr_trig  = reg_wr & hit(reg_addr, `ATS_OFF_TRIG_SEL);
    wire wr_uflow = reg_wr & hit(reg_addr, `ATS_OFF_UFLOW);
    wire wr_init  = reg_wr & hit(reg_addr, `ATS_OFF_INITIATE);
    wire wr_en    = reg_wr & hit(reg_addr, `ATS_OFF_SEQ_ENABLE);
    wire wr_mask  = reg_wr & hit(reg_addr, `ATS_OFF_INT_MASK);

    // ============================================================
    // Underflow detection
    // Lowest sequencer with a request is served; one FIFO read per cycle
    reg [NSEQ-1:0] sel_rd;
    integer        i;
    always @* begin
        sel_rd = {NSEQ{1'b0}};
        for (i = NSEQ - 1; i >= 0; i = i - 1) begin
            if (fifo_rd_req[i]) begin
                sel_rd = {NSEQ{1'b0}};
                sel_rd[i] = 1'b1;
            end
        end
    end

    wire [NSEQ-1:0] uflow_evt = sel_rd & fifo_empty;
    wire [NSEQ-1:0] clr_mask  = wr_uflow ? reg_wdata[NSEQ-1:0] : {NSEQ{1'b0}};
    wire [NSEQ-1:0] flags_d   = (fifo_underflow_flags_q & ~clr_mask) | uflow_evt;

    wire [DW-1:0] sel_data = |(sel_rd & ~fifo_empty) ? fifo_rd_data : {DW{1'b0}};

    // ============================================================
    // Registers
    always @(posedge clk) begin
        if (srst) begin
            trigger_source_select_q   <= `ATS_TRIG_RESET;
            fifo_underflow_flags_q    <= `ATS_FLAGS_RESET;
            sequencer_active_enable_q <= `ATS_FLAGS_RESET;
            int_mask_q                <= `ATS_FLAGS_RESET;
            initiate_q                <= `ATS_FLAGS_RESET;
            fifo_pop_q                <= `ATS_FLAGS_RESET;
            rd_data_q                 <= {DW{1'b0}};
            rd_valid_q                <= 1'b0;
            irq_q                     <= 1'b0;
        end else if (clk_en) begin
            if (wr_trig) begin
                trigger_source_select_q <= reg_wdata[15:0];
            end
            if (wr_en) begin
                sequencer_active_enable_q <= reg_wdata[NSEQ-1:0];
            end
            if (wr_mask) begin
                int_mask_q <= reg_wdata[NSEQ-1:0];
            end
            // Initiate is write-only: a one-cycle request per written bit
            initiate_q             <= wr_init ? reg_wdata[NSEQ-1:0] : {NSEQ{1'b0}};
            fifo_underflow_flags_q <= flags_d;
            fifo_pop_q             <= sel_rd & ~fifo_empty;
            rd_data_q              <= sel_data;
            rd_valid_q             <= |sel_rd;
            irq_q                  <= |(flags_d & int_mask_q);
        end
    end

    // ============================================================
    // Read port
    // Reserved bits read zero, well within the undefined allowance
    always @(posedge clk) begin
        if (srst) begin
            reg_rdata_q <= `ATS_ZERO32;
        end else if (clk_en) begin
            reg_rdata_q <= `ATS_ZERO32;
            if (reg_rd) begin
                case (reg_addr)
                    `ATS_OFF_TRIG_SEL:   reg_rdata_q <= {16'h0000, trigger_source_select_q};
                    `ATS_OFF_UFLOW:      reg_rdata_q <= {28'h0000000, fifo_underflow_flags_q};
                    `ATS_OFF_SEQ_ENABLE: reg_rdata_q <= {28'h0000000, sequencer_active_enable_q};
                    `ATS_OFF_INT_MASK:   reg_rdata_q <= {28'h0000000, int_mask_q};
                    default:             reg_rdata_q <= `ATS_ZERO32;
                endcase
            end
        end
    end

    // ============================================================
    // Per-sequencer trigger selection
    genvar g;
    generate
        for (g = 0; g < NSEQ; g = g + 1) begin : seq
            ats_trig_mux u_mux (
                .clk         (clk),
                .srst        (srst),
                .clk_en      (clk_en),
                .field       (trigger_source_select_q[g*4 +: 4]),
                .enabled     (sequencer_active_enable_q[g]),
                .initiate    (initiate_q[g]),
                .comp0_evt   (comp0_evt),
                .ext_pin_evt (external_trigger_pin),
                .timer_evt   (timer_evt),
                .pgen_a_evt  (pulse_gen_a_trigger),
                .pgen_b_evt  (pulse_gen_b_trigger),
                .pgen_c_evt  (pulse_gen_c_trigger),
                .start_q     (seq_start_q[g])
            );
        end
    endgenerate

endmodule

// file: verification/ats_fifo_model.sv
// Sequencer FIFO read side as seen by the trigger select block
`timescale 1ns/100ps
// ============================================================
// FIFO model
module ats_fifo_model (
    // Clock and reset
    input  wire        clk,
    input  wire        srst,
    // FIFO side
    input  wire [3:0]  fifo_pop_q,
    output wire [3:0]  fifo_empty,
    output wire [31:0] fifo_rd_data
);
    reg [1:0] cnt_q;
    // Only sequencer 0 holds words, so one drain reaches empty quickly
    always @(posedge clk) begin
        if (srst) begin
            cnt_q <= 2'h2;
        end else if (fifo_pop_q[0] && cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end
    end
    assign fifo_empty = {3'h7, cnt_q == 2'h0};
    // Empty FIFO shows garbage; the block itself must zero the data
    assign fifo_rd_data = (cnt_q == 2'h0) ? 32'h5a5a_5a5a : {30'h25a5_a5a5, cnt_q};
endmodule

// file: verification/ats_top_chk.sv
// Port checker of the trigger select block
`timescale 1ns/100ps
// ============================================================
// Checker
module ats_top_chk #(
    parameter NSEQ = 4,
    parameter DW   = 32
) (
    // Clock and reset
    input wire            clk,
    input wire            srst,
    input wire            clk_en,
    // Register port
    input wire            reg_rd,
    input wire            reg_wr,
    input wire [31:0]     reg_rdata_q,
    // Sequencer and FIFO side
    input wire [NSEQ-1:0] seq_start_q,
    input wire [NSEQ-1:0] fifo_rd_req,
    input wire [NSEQ-1:0] fifo_empty,
    input wire [DW-1:0]   fifo_rd_data,
    input wire [NSEQ-1:0] fifo_pop_q,
    input wire [DW-1:0]   rd_data_q,
    input wire            rd_valid_q,
    input wire            irq_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst || !clk_en);
    rd_idle_a: assert property (!reg_rd |=> reg_rdata_q == 32'h0) else $error("read data not idle");
    uf_zero_a: assert property (fifo_rd_req[0] && fifo_empty[0] |=> rd_valid_q
        && rd_data_q == 0 && fifo_pop_q == 0) else $error("underflow read wrong");
    pop_data_a: assert property (fifo_rd_req[0] && !fifo_empty[0] |=> fifo_pop_q == 1
        && rd_data_q == $past(fifo_rd_data)) else $error("served read wrong");
    irq_fall_a: assert property ($fell(irq_q) |-> $past(reg_wr)) else $error("irq fell alone");
    no_valid_a: assert property (!(|fifo_rd_req) |=> !rd_valid_q) else $error("valid with no read");
    pop_empty_a: assert property ((fifo_pop_q & $past(fifo_empty)) == 0) else $error("pop empty");
    one_pop_a: assert property ($onehot0(fifo_pop_q)) else $error("several pops");
    reset_out_a: assert property ($past(srst) |-> seq_start_q == 0 && !irq_q)
        else $error("outputs not reset");
endmodule
bind ats_top ats_top_chk #(.NSEQ(NSEQ), .DW(DW)) u_ats_top_chk (.clk, .srst, .clk_en, .reg_rd,
    .reg_wr, .reg_rdata_q, .seq_start_q, .fifo_rd_req, .fifo_empty, .fifo_rd_data, .fifo_pop_q,
    .rd_data_q, .rd_valid_q, .irq_q);

// file: verification/ats_top_tb.sv
// Testbench of the trigger select block
`timescale 1ns/100ps
`include "ats_regs.vh"
// ============================================================
// Bench
module ats_top_tb;
    reg         clk, srst, clk_en, reg_wr, reg_rd;
    reg  [7:0]  reg_addr;
    reg  [31:0] reg_wdata, d;
    reg  [5:0]  evt;
    reg  [3:0]  fifo_rd_req;
    wire [31:0] reg_rdata_q, fifo_rd_data, rd_data_q;
    wire [3:0]  seq_start_q, fifo_empty, fifo_pop_q;
    wire        rd_valid_q, irq_q;
    int         n_fail, total_checks;
    localparam logic [3:0] CODES [6] = '{`ATS_TRIG_COMP0, `ATS_TRIG_EXT_PIN, `ATS_TRIG_TIMER,
        `ATS_TRIG_PGEN_A, `ATS_TRIG_PGEN_B, `ATS_TRIG_PGEN_C};
    ats_top u_ats_top (.clk(clk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .comp0_evt(evt[0]), .external_trigger_pin(evt[1]), .timer_evt(evt[2]),
        .pulse_gen_a_trigger(evt[3]), .pulse_gen_b_trigger(evt[4]),
        .pulse_gen_c_trigger(evt[5]), .seq_start_q(seq_start_q), .fifo_rd_req(fifo_rd_req),
        .fifo_empty(fifo_empty), .fifo_rd_data(fifo_rd_data), .fifo_pop_q(fifo_pop_q),
        .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .irq_q(irq_q));
    ats_fifo_model u_ats_fifo_model (.clk(clk), .srst(srst), .fifo_pop_q(fifo_pop_q),
        .fifo_empty(fifo_empty), .fifo_rd_data(fifo_rd_data));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask
    // Reserved bits are written as zero except at the unmapped address 8'h3c
    task wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] req);
        @(posedge clk) {reg_wr, reg_addr, reg_wdata, fifo_rd_req} <= {1'b1, a, v, req};
        @(posedge clk) {reg_wr, fifo_rd_req} <= 5'h0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk) reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask
    task ev(input logic [5:0] v);
        @(posedge clk) evt <= v;
        @(posedge clk) #1;
    endtask
    task t_rst;
        @(posedge clk) srst <= 1'b1;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rd(`ATS_OFF_TRIG_SEL);
        chk(d, `ATS_ZERO32);
        rd(`ATS_OFF_UFLOW);
        chk(d, `ATS_ZERO32);
        rd(8'h3c);
        chk(d, `ATS_ZERO32);
        $display("test reset done");
    endtask
    task t_trig;
        logic [15:0] f;
        wr(`ATS_OFF_SEQ_ENABLE, 32'hf, 4'h0);
        for (int n = 0; n < 4; n++) begin
            for (int k = 0; k < 6; k++) begin
                f = 16'h2222;
                f[n*4+:4] = CODES[k];
                wr(`ATS_OFF_TRIG_SEL, {16'h0, f}, 4'h0);
                rd(`ATS_OFF_TRIG_SEL);
                chk(d, {16'h0, f});
                ev(6'h3f ^ 6'(1 << k));
                chk(32'(seq_start_q), 32'h0);
                ev(6'(1 << k));
                chk(32'(seq_start_q), 32'(1 << n));
            end
            f[n*4+:4] = `ATS_TRIG_ALWAYS;
            wr(`ATS_OFF_TRIG_SEL, {16'h0, f}, 4'h0);
            ev(6'h0);
            chk(32'(seq_start_q), 32'(1 << n));
            f[n*4+:4] = `ATS_TRIG_PROC;
            wr(`ATS_OFF_TRIG_SEL, {16'h0, f}, 4'h0);
            wr(`ATS_OFF_INITIATE, 32'(1 << n), 4'h0);
            // Write edge loads the initiate pulse; the start follows one edge later
            @(posedge clk) #1;
            chk(32'(seq_start_q), 32'(1 << n));
        end
        $display("test trigger done");
    endtask
    task t_uf;
        wr(`ATS_OFF_INT_MASK, 32'h0, 4'h4);
        rd(`ATS_OFF_UFLOW);
        chk(d, 32'h4);
        chk(32'(irq_q), 32'h0);
        wr(`ATS_OFF_INT_MASK, 32'h4, 4'h0);
        rd(`ATS_OFF_UFLOW);
        chk(32'(irq_q), 32'h1);
        wr(`ATS_OFF_UFLOW, 32'h0, 4'h0);
        rd(`ATS_OFF_UFLOW);
        chk(d, 32'h4);
        wr(`ATS_OFF_UFLOW, 32'h4, 4'h0);
        rd(`ATS_OFF_UFLOW);
        chk(d, 32'h0);
        chk(32'(irq_q), 32'h0);
        wr(`ATS_OFF_UFLOW, 32'h2, 4'h2);
        rd(`ATS_OFF_UFLOW);
        chk(d, 32'h2);
        // Unmapped writes double as plain FIFO reads of sequencer 0
        repeat (3) wr(8'h3c, 32'hf, 4'h1);
        rd(`ATS_OFF_UFLOW);
        chk(d, 32'h3);
        $display("test underflow done");
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {srst, clk_en, reg_wr, reg_rd, reg_addr, reg_wdata, evt, fifo_rd_req} = {2'h3, 52'h0};
        t_rst();
        t_trig();
        t_uf();
        t_rst();
        summarize();
    end
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
endmodule
